// >>> rtl/instr_decode_map.vh
/*
 holds field positions, encodings and timing counts for the instruction decoder.
 assumes the includer wants plain macros; no processes live here.
*/
// Behaviour
// - single-word instructions are 24 bits with an 8-bit opcode in the top bits.
// - exactly three two-word instructions assemble 48 bits from consecutive words.
// - a lone second word, top eight bits zero, executes as a no-operation.
// - every two-word instruction takes two cycles.
// - single-word takes one cycle, two when condition true or PC changes.
// - branches, indirect call/jump, table ops and returns take two or three cycles.
// - a performed skip takes two cycles, three if skipping a two-word instruction.
// - double-word moves take two cycles.
// - file-register ops use working register zero; destination is file or W0.
// - file-register address field spans zero to 0x1fff.
// - ten-bit literal is unsigned; byte mode 0..255, word mode 0..1023.
// - call literal is 23-bit unsigned program address with LSB zero.
// - accumulator write-back selects W13 or [W13] post-increment by two.
// - square pair field encodes only self-pairs of W4 to W7.
// - multiply pair field encodes the six distinct pairs of W4 to W7.
// - X prefetch selects W8/W9 modes, W9 plus W12, or none.
// - Y prefetch selects W10/W11 modes, W11 plus W12, or none.
// - X and Y prefetch destinations select one of W4 to W7.
// - DSP accumulator field selects exactly accumulator A or B.
// - ten-bit signed literal is sign-extended, range -512 to 511.
// - base working register field selects any of W0 to W15 directly.
// - with debug enabled, lowest 80 RAM bytes and two pins are reserved.
`ifndef INSTR_DECODE_MAP_VH
`define INSTR_DECODE_MAP_VH

`define IW_WIDTH 24
`define OPC_HI 23
`define OPC_LO 16
// opcode values of the three two-word instructions, and of the single-word OPC_DO_REG
`define OPC_CALL_ABS 8'h02
`define OPC_GOTO_ABS 8'h04
`define OPC_DO_LIT 8'h08
`define OPC_DO_REG 8'h09
// opcode values and ranges for table, control, skip, move, file, dsp and nop decoding
`define OPC_TBL_LO 8'hba
`define OPC_TBL_HI 8'hbb
`define OPC_TBL_WLO 8'hbe
`define OPC_TBL_WHI 8'hbf
`define OPC_BRA_UNC 8'h37
`define OPC_BRA_COND_LO 8'h30
`define OPC_BRA_COND_HI 8'h3f
`define OPC_IND_CTRL 8'h01
`define OPC_RETURN 8'h06
`define OPC_MOV_D_LO 8'hbe
`define OPC_SKIP_LO 8'ha4
`define OPC_SKIP_HI 8'ha7
`define OPC_CPS_LO 8'he6
`define OPC_CPS_HI 8'he7
`define OPC_FILE_LO 8'hb4
`define OPC_FILE_HI 8'hef
`define OPC_DSP_LO 8'hc0
`define OPC_DSP_HI 8'hc7
`define OPC_NOP 8'h00
// operand field positions
`define F_ADDR_HI 12
`define F_ADDR_LO 0
`define F_ADDR_MAX 13'h1fff
`define F_DEST_BIT 13
`define F_BYTE_BIT 14
`define TEN_BIT_UNSIGNED_LITERAL_HI 13
`define TEN_BIT_UNSIGNED_LITERAL_LO 4
`define BASE_HI 14
`define BASE_LO 11
`define SRC_HI 3
`define SRC_LO 0
`define DST_HI 10
`define DST_LO 7
`define ACC_BIT 15
`define MPAIR_HI 18
`define MPAIR_LO 16
`define XPF_HI 13
`define XPF_LO 10
`define YPF_HI 5
`define YPF_LO 2
`define XD_HI 9
`define XD_LO 8
`define YD_HI 7
`define YD_LO 6
`define AWB_HI 1
`define AWB_LO 0
`define FILE_OP_WORK_REG_NUM 4'h0
`define W4_NUM 4'h4
`define W13_NUM 4'hd
`define PF_NONE 4'h4
// debug reservation
`define DBG_RAM_BYTES 8'h50
// cycle counts
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3

`endif

// >>> rtl/instr_decode.v
/*
 instruction decoder: splits 24-bit words into operand fields, joins two-word
 instructions to 48 bits and gives the cycle count for pipeline control.
 operand views are registered on a single word, the call target on the word that ends a pair;
 the pipeline picks the view that the opcode calls for.
 debug reservation flags are registered too and lag their inputs by one clock.
 assumes fetch presents words in program order with a valid strobe, and the
 execute stage reports condition and skip outcomes in the cycle of the word.
 words are always accepted; there is no back-pressure toward fetch.
*/
`timescale 1ns/1ns
`include "instr_decode_map.vh"

module instr_decode (
    input wire clk,
    input wire rst_n,
    input wire word_valid,
    input wire [23:0] word_in,
    input wire cond_true,
    input wire skip_taken,
    input wire skip_target_two_word,
    input wire debug_enable,
    input wire [15:0] data_addr_in,
    output wire word_ready,
    output reg dec_valid_reg,
    output reg [47:0] instr_reg,
    output reg [7:0] opcode_reg,
    output reg two_word_reg,
    output reg [1:0] cycle_count_reg,
    output reg [12:0] file_addr_reg,
    output reg file_dest_file_op_work_reg_reg,
    output reg [3:0] file_op_work_reg,
    output reg [9:0] ten_bit_unsigned_literal,
    output reg [15:0] ten_bit_signed_literal,
    output reg [23:0] call_target_literal,
    output reg [3:0] base_work_reg,
    output reg [3:0] source_work_reg,
    output reg [3:0] dest_work_reg,
    output reg acc_sel_b_reg,
    output reg [3:0] square_reg_pair,
    output reg [7:0] multiply_reg_pair,
    output reg pair_illegal_reg,
    output reg [3:0] x_prefetch_addr,
    output reg [3:0] y_prefetch_addr,
    output reg [3:0] x_prefetch_dest_reg,
    output reg [3:0] y_prefetch_dest_reg,
    output reg [1:0] acc_writeback_dest,
    output wire debug_ram_reserved,
    output wire debug_pins_reserved
);

    localparam ST_FIRST = 2'b01;
    localparam ST_SECOND = 2'b10;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [23:0] first_word_reg;
    wire [7:0] opc;
    wire is_two_word;
    wire is_ctrl_multi;
    wire is_skip;
    wire is_cond_bra;
    wire is_mov_d;
    reg [1:0] cyc_single;
    wire [3:0] mp;
    wire take_pair;
    wire take_single;
    reg [7:0] mult_pair_next;
    reg [9:0] ulit_next;
    reg debug_ram_res_reg;
    reg debug_pins_res_reg;

    assign word_ready = 1'b1;
    assign opc = word_in[`OPC_HI:`OPC_LO];
    // a lone second word has opcode zero, so it can never start a pair
    assign is_two_word = (opc == `OPC_CALL_ABS) || (opc == `OPC_GOTO_ABS) || (opc == `OPC_DO_LIT);
    assign is_cond_bra = (opc >= `OPC_BRA_COND_LO) && (opc <= `OPC_BRA_COND_HI) && (opc != `OPC_BRA_UNC);
    assign is_ctrl_multi = (opc == `OPC_BRA_UNC) || (opc == `OPC_IND_CTRL) || (opc == `OPC_RETURN)
        || (opc == `OPC_TBL_LO) || (opc == `OPC_TBL_HI) || (opc == `OPC_TBL_WLO) || (opc == `OPC_TBL_WHI);
    // skip-type words: bit tests and compare-and-skip
    assign is_skip = ((opc >= `OPC_SKIP_LO) && (opc <= `OPC_SKIP_HI))
        || ((opc >= `OPC_CPS_LO) && (opc <= `OPC_CPS_HI));
    assign is_mov_d = (opc == `OPC_MOV_D_LO) || (opc == `OPC_DO_REG);

    // lowest 80 data bytes leave general use; registered so the ram guard sees no decode glitch
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            debug_ram_res_reg <= 1'b0;
        else
            debug_ram_res_reg <= debug_enable && (data_addr_in < {8'h00, `DBG_RAM_BYTES});
    end

    // both debug pins are withdrawn together
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            debug_pins_res_reg <= 1'b0;
        else
            debug_pins_res_reg <= debug_enable;
    end

    assign debug_ram_reserved = debug_ram_res_reg;
    assign debug_pins_reserved = debug_pins_res_reg;

    // cycle count for a single-word instruction
    always @*
    begin
        cyc_single = `CYC_ONE;
        if (opc == `OPC_NOP)
            cyc_single = `CYC_ONE;
        else if (is_ctrl_multi)
            cyc_single = (opc == `OPC_RETURN) ? `CYC_THREE : `CYC_TWO;
        else if (is_skip && skip_taken)
            cyc_single = skip_target_two_word ? `CYC_THREE : `CYC_TWO;
        else if (is_mov_d)
            cyc_single = `CYC_TWO;
        else if (is_cond_bra && cond_true)
            cyc_single = `CYC_TWO;
    end

    // pairing state: the first word waits for its partner
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_FIRST:
            begin
                if (word_valid && is_two_word)
                    state_next = ST_SECOND;
            end
            ST_SECOND:
            begin
                if (word_valid)
                    state_next = ST_FIRST;
            end
            default:
                state_next = ST_FIRST;
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_FIRST;
            first_word_reg <= 24'h000000;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == ST_FIRST && word_valid && is_two_word)
                first_word_reg <= word_in;
        end
    end

    assign mp = {1'b0, word_in[`MPAIR_HI:`MPAIR_LO]};
    // a word completes an instruction as the partner of a held half, or alone
    assign take_pair = word_valid && (state_reg == ST_SECOND);
    assign take_single = word_valid && (state_reg == ST_FIRST) && !is_two_word;

    // six distinct pairs; codes 6 and 7 have no pairing and read as zero
    always @*
    begin
        mult_pair_next = 8'h00;
        case (mp)
            4'h0: mult_pair_next = 8'h45;
            4'h1: mult_pair_next = 8'h46;
            4'h2: mult_pair_next = 8'h47;
            4'h3: mult_pair_next = 8'h56;
            4'h4: mult_pair_next = 8'h57;
            4'h5: mult_pair_next = 8'h67;
            default: mult_pair_next = 8'h00;
        endcase
    end

    // byte mode keeps only the low eight bits of the literal
    always @*
    begin
        ulit_next = word_in[`TEN_BIT_UNSIGNED_LITERAL_HI:`TEN_BIT_UNSIGNED_LITERAL_LO];
        if (word_in[`F_BYTE_BIT])
            ulit_next = {2'b00, word_in[`TEN_BIT_UNSIGNED_LITERAL_LO+7:`TEN_BIT_UNSIGNED_LITERAL_LO]};
    end

    // completion strobe, raw instruction and cycle count
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dec_valid_reg <= 1'b0;
            instr_reg <= 48'h000000000000;
            opcode_reg <= 8'h00;
            two_word_reg <= 1'b0;
            cycle_count_reg <= 2'h0;
        end
        else if (take_pair)
        begin
            // second word completes the 48-bit form
            dec_valid_reg <= 1'b1;
            instr_reg <= {first_word_reg, word_in};
            opcode_reg <= first_word_reg[`OPC_HI:`OPC_LO];
            two_word_reg <= 1'b1;
            cycle_count_reg <= `CYC_TWO;
        end
        else if (take_single)
        begin
            dec_valid_reg <= 1'b1;
            instr_reg <= {24'h000000, word_in};
            opcode_reg <= opc;
            two_word_reg <= 1'b0;
            cycle_count_reg <= cyc_single;
        end
        else
        begin
            // strobe lasts one cycle; the fields stand until the next one
            dec_valid_reg <= 1'b0;
        end
    end

    // call target changes only when a pair completes; lsb forced to zero
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            call_target_literal <= 24'h000000;
        else if (take_pair)
            call_target_literal <= {1'b0, word_in[6:0], first_word_reg[15:1], 1'b0};
    end

    // file-register operands: address, destination choice and fixed work register
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            file_addr_reg <= 13'h0000;
            file_dest_file_op_work_reg_reg <= 1'b0;
            file_op_work_reg <= 4'h0;
        end
        else if (take_single)
        begin
            file_addr_reg <= word_in[`F_ADDR_HI:`F_ADDR_LO] & `F_ADDR_MAX;
            file_dest_file_op_work_reg_reg <= ~word_in[`F_DEST_BIT];
            file_op_work_reg <= `FILE_OP_WORK_REG_NUM;
        end
    end

    // unsigned literal view of the operand bits
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ten_bit_unsigned_literal <= 10'h000;
        else if (take_single)
            ten_bit_unsigned_literal <= ulit_next;
    end

    // signed view of the same bits, widened so the datapath needs no extension
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ten_bit_signed_literal <= 16'h0000;
        else if (take_single)
            ten_bit_signed_literal <= {{6{word_in[`TEN_BIT_UNSIGNED_LITERAL_HI]}}, word_in[`TEN_BIT_UNSIGNED_LITERAL_HI:`TEN_BIT_UNSIGNED_LITERAL_LO]};
    end

    // working register selects, all direct
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_work_reg <= 4'h0;
            source_work_reg <= 4'h0;
            dest_work_reg <= 4'h0;
        end
        else if (take_single)
        begin
            base_work_reg <= word_in[`BASE_HI:`BASE_LO];
            source_work_reg <= word_in[`SRC_HI:`SRC_LO];
            dest_work_reg <= word_in[`DST_HI:`DST_LO];
        end
    end

    // one bit picks the accumulator, so no third choice can arise
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            acc_sel_b_reg <= 1'b0;
        else if (take_single)
            acc_sel_b_reg <= word_in[`ACC_BIT];
    end

    // multiplier operand pairs; bad codes are flagged only for dsp opcodes
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            square_reg_pair <= 4'h0;
            multiply_reg_pair <= 8'h00;
            pair_illegal_reg <= 1'b0;
        end
        else if (take_single)
        begin
            // squares: codes 0..3 map to W4..W7 paired with itself
            square_reg_pair <= `W4_NUM + {2'b00, word_in[`MPAIR_LO+1:`MPAIR_LO]};
            multiply_reg_pair <= mult_pair_next;
            pair_illegal_reg <= (opc >= `OPC_DSP_LO) && (opc <= `OPC_DSP_HI) && (mp > 4'h5);
        end
    end

    // x prefetch codes: 0..3 W8 ops, 4 none, 5..7 W8 minus, 8..11 W9 ops, 12 W9+W12, 13..15 W9 minus
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            x_prefetch_addr <= 4'h0;
            x_prefetch_dest_reg <= 4'h0;
        end
        else if (take_single)
        begin
            x_prefetch_addr <= word_in[`XPF_HI:`XPF_LO];
            x_prefetch_dest_reg <= `W4_NUM + {2'b00, word_in[`XD_HI:`XD_LO]};
        end
    end

    // y prefetch codes follow the x layout with W10 and W11 in place of W8 and W9
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            y_prefetch_addr <= 4'h0;
            y_prefetch_dest_reg <= 4'h0;
        end
        else if (take_single)
        begin
            y_prefetch_addr <= word_in[`YPF_HI:`YPF_LO];
            y_prefetch_dest_reg <= `W4_NUM + {2'b00, word_in[`YD_HI:`YD_LO]};
        end
    end

    // write-back: 0 = W13 direct, 1 = [W13]+=2, others no write-back
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            acc_writeback_dest <= 2'h0;
        else if (take_single)
            acc_writeback_dest <= word_in[`AWB_HI:`AWB_LO];
    end

endmodule // instr_decode

// >>> dv/instr_decode_properties.sv
/*
 checker for the instruction decoder: ties decoded outputs to the words taken.
 assumes it is bound to instr_decode and sees only its ports.
*/
`timescale 1ns/1ns
module instr_decode_checker (
    input wire clk,
    input wire rst_n,
    input wire word_valid,
    input wire [23:0] word_in,
    input wire dec_valid_reg,
    input wire [47:0] instr_reg,
    input wire [7:0] opcode_reg,
    input wire two_word_reg,
    input wire [1:0] cycle_count_reg,
    input wire [15:0] ten_bit_signed_literal,
    input wire [3:0] square_reg_pair
);
    reg pend_reg;
    wire first_w = word_valid && !pend_reg && (word_in[23:16] inside {8'h02, 8'h04, 8'h08});
    // tracks a held first half; the next taken word always completes it
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            pend_reg <= 1'b0;
        else if (word_valid)
            pend_reg <= first_w;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_single; word_valid && !pend_reg && !first_w |=> dec_valid_reg && !two_word_reg
        && opcode_reg == $past(word_in[23:16]); endproperty
    a_single: assert property (p_single) else $error("single word not decoded");
    property p_hold; first_w |=> !dec_valid_reg; endproperty
    a_hold: assert property (p_hold) else $error("first half decoded alone");
    property p_pair; word_valid && pend_reg |=> dec_valid_reg && two_word_reg
        && instr_reg[23:0] == $past(word_in); endproperty
    a_pair: assert property (p_pair) else $error("pair not joined");
    property p_pair_cyc; word_valid && pend_reg |=> cycle_count_reg == 2'h2; endproperty
    a_pair_cyc: assert property (p_pair_cyc) else $error("pair cycle count");
    property p_nop; word_valid && !pend_reg && word_in[23:16] == 8'h00 |=> cycle_count_reg == 2'h1; endproperty
    a_nop: assert property (p_nop) else $error("lone second word not one cycle");
    property p_pulse; !word_valid |=> !dec_valid_reg; endproperty
    a_pulse: assert property (p_pulse) else $error("decode pulse without word");
    property p_sext; word_valid && !pend_reg && !first_w |=> ten_bit_signed_literal
        == {{6{$past(word_in[13])}}, $past(word_in[13:4])}; endproperty
    a_sext: assert property (p_sext) else $error("signed literal not extended");
    property p_square; word_valid && !pend_reg && !first_w |=> square_reg_pair
        == {2'b01, $past(word_in[17:16])}; endproperty
    a_square: assert property (p_square) else $error("square pair outside w4 to w7");
endmodule // instr_decode_checker
bind instr_decode instr_decode_checker i_chk (.clk, .rst_n, .word_valid, .word_in, .dec_valid_reg, .instr_reg,
    .opcode_reg, .two_word_reg, .cycle_count_reg, .ten_bit_signed_literal, .square_reg_pair);

// >>> dv/fetch_model.sv
/*
 fetch stage model: offers program words in order with a valid level.
 assumes callers enter its task just after a rising clock edge.
*/
`timescale 1ns/1ns
module fetch_model (
    input wire clk,
    output reg word_valid,
    output reg [23:0] word_in
);
    initial word_valid = 1'b0;
    initial word_in = 24'h0;
    // a released bus shows the inverse word so stale data never matches
    task offer(input [23:0] w, input last);
        begin
            word_valid <= 1'b1;
            word_in <= w;
            @(posedge clk);
            if (last)
            begin
                word_valid <= 1'b0;
                word_in <= ~w;
            end
        end
    endtask
endmodule // fetch_model

// >>> dv/test_dsc_instruction_decode.sv
/*
 self-checking bench for the instruction decoder: corner and random words.
 assumes fetch_model and the bound checker are compiled first.
*/
`timescale 1ns/1ns
module test_dsc_instruction_decode;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg cond_true = 1'b0, skip_taken = 1'b0, skip_target_two_word = 1'b0, debug_enable = 1'b0;
    reg [15:0] data_addr_in = 16'h0;
    wire word_valid, word_ready, dec_valid_reg, two_word_reg, file_dest_file_op_work_reg_reg, acc_sel_b_reg;
    wire pair_illegal_reg, debug_ram_reserved, debug_pins_reserved;
    wire [1:0] cycle_count_reg, acc_writeback_dest;
    wire [3:0] file_op_work_reg, base_work_reg, source_work_reg, dest_work_reg, square_reg_pair;
    wire [3:0] x_prefetch_addr, y_prefetch_addr, x_prefetch_dest_reg, y_prefetch_dest_reg;
    wire [7:0] opcode_reg, multiply_reg_pair;
    wire [9:0] ten_bit_unsigned_literal;
    wire [12:0] file_addr_reg;
    wire [15:0] ten_bit_signed_literal;
    wire [23:0] word_in, call_target_literal;
    wire [47:0] instr_reg;
    integer seed = 17987, miscompares = 0, checked = 0, i;
    reg [23:0] w;
    localparam [47:0] pairs = 48'h675756474645;
    // {cond, skip, skip two-word, word}
    reg [26:0] corners [0:21] = '{27'h000abcd, 27'h0b42000, 27'h0b41ff0, 27'h0b47ff0, 27'h0371234,
        27'h0065678, 27'h0011111, 27'h0092222, 27'h0ba0000, 27'h0bb0000, 27'h0be0000, 27'h0bf0000,
        27'h43a1234, 27'h03a1234, 27'h2a50000, 27'h3a50000, 27'h3e60000, 27'h0e70000, 27'h0c7ffff,
        27'h0c5aaaa, 27'h0c0f0f0, 27'h0b41fff};
    instr_decode i_dut (.clk, .rst_n, .word_valid, .word_in, .cond_true, .skip_taken, .skip_target_two_word,
        .debug_enable, .data_addr_in, .word_ready, .dec_valid_reg, .instr_reg, .opcode_reg, .two_word_reg,
        .cycle_count_reg, .file_addr_reg, .file_dest_file_op_work_reg_reg, .file_op_work_reg, .ten_bit_unsigned_literal,
        .ten_bit_signed_literal, .call_target_literal, .base_work_reg, .source_work_reg, .dest_work_reg,
        .acc_sel_b_reg, .square_reg_pair, .multiply_reg_pair, .pair_illegal_reg, .x_prefetch_addr,
        .y_prefetch_addr, .x_prefetch_dest_reg, .y_prefetch_dest_reg, .acc_writeback_dest,
        .debug_ram_reserved, .debug_pins_reserved);
    fetch_model i_fetch (.clk, .word_valid, .word_in);
    always #50 clk = ~clk;
    task check(input [8*7-1:0] name, input [63:0] seen, input [63:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp)
            begin
                miscompares = miscompares + 1;
                $display("BAD %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // expected cycles of a single word under the present outcome inputs
    function [1:0] cyc(input [7:0] op);
        begin
            cyc = (op inside {8'h37, 8'h01, 8'h09, 8'hba, 8'hbb, 8'hbe, 8'hbf}) ? 2'h2 : 2'h1;
            if (op == 8'h06)
                cyc = 2'h3;
            if (op inside {[8'h30:8'h3f]} && cond_true)
                cyc = 2'h2;
            if (op inside {[8'ha4:8'ha7], 8'he6, 8'he7} && skip_taken)
                cyc = skip_target_two_word ? 2'h3 : 2'h2;
        end
    endfunction
    task send(input [23:0] a, input [23:0] b, input pair, input [2:0] c);
        begin
            {cond_true, skip_taken, skip_target_two_word} <= c;
            i_fetch.offer(a, !pair);
            if (pair)
                i_fetch.offer(b, 1'b1);
            #1;
            check("valid", dec_valid_reg, 1'b1);
            check("opcode", opcode_reg, a[23:16]);
            check("instr", {two_word_reg, instr_reg}, pair ? {1'b1, a, b} : {25'h0, a});
            check("cycles", cycle_count_reg, pair ? 2'h2 : cyc(a[23:16]));
            if (pair)
                check("target", call_target_literal, {1'b0, b[6:0], a[15:1], 1'b0});
            else
            begin
                check("file", {file_addr_reg, file_dest_file_op_work_reg_reg, file_op_work_reg}, {a[12:0], ~a[13], 4'h0});
                check("square", square_reg_pair, 4'h4 + a[17:16]);
                check("ulit", ten_bit_unsigned_literal, a[14] ? {2'b0, a[11:4]} : a[13:4]);
                check("slit", ten_bit_signed_literal, {{6{a[13]}}, a[13:4]});
                check("regs", {base_work_reg, source_work_reg, dest_work_reg}, {a[14:11], a[3:0], a[10:7]});
                check("acc", acc_sel_b_reg, a[15]);
                check("mult", multiply_reg_pair, a[18:16] > 3'h5 ? 8'h00 : pairs[a[18:16]*8 +: 8]);
                check("illegal", pair_illegal_reg, a[23:19] == 5'h18 && a[18:16] > 3'h5);
                check("xyaddr", {x_prefetch_addr, y_prefetch_addr}, {a[13:10], a[5:2]});
                check("xydest", {x_prefetch_dest_reg, y_prefetch_dest_reg}, {4'h4 + a[9:8], 4'h4 + a[7:6]});
                check("awb", acc_writeback_dest, a[1:0]);
            end
            @(posedge clk);
        end
    endtask
    task conclude;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // corners, then every two-word opcode, then random words and a mid-run reset
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 22; i = i + 1)
            send(corners[i][23:0], 24'h0, 1'b0, corners[i][26:24]);
        for (i = 0; i < 300; i = i + 1)
        begin
            w = 24'($random(seed));
            if (i < 3)
                w[23:16] = 8'h02 << i;
            send(w, {8'h00, 16'($random(seed))}, w[23:16] inside {8'h02, 8'h04, 8'h08}, 3'($random(seed)));
        end
        for (i = 0; i < 8; i = i + 1)
        begin
            debug_enable <= i[0];
            data_addr_in <= i[2] ? 16'($random(seed)) : 16'h004f + i[1];
            @(posedge clk);
            #1;
            check("dbgram", debug_ram_reserved, i[0] && data_addr_in < 16'h0050);
            check("dbgpin", {debug_pins_reserved, word_ready}, {i[0], 1'b1});
        end
        rst_n <= 1'b0;
        #1;
        check("reset", {dec_valid_reg, opcode_reg, cycle_count_reg}, 11'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        send(24'h3a0000, 24'h0, 1'b0, 3'h4);
        conclude;
    end
endmodule // test_dsc_instruction_decode
